// ===== core/tbsp_pkg.sv
/*
 * Constants for the test-bus selection and pseudo-random sequence block.
 * Assumes an 8-bit register port addressed by byte offset.
 */
package tbsp_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int BUS_SEL_W = 5;
    localparam int BIT_SEL_W = 3;
    localparam int NUM_BUSES = 32;
    localparam int PAR_W = 6;
    localparam int LFSR_W = 15;

    // Register offsets
    localparam logic [7:0] OFS_RESERVED_TEST_SLOT = 8'h30;
    localparam logic [7:0] OFS_TEST_SIGNAL_SELECT_ONE = 8'h31;
    localparam logic [7:0] OFS_TEST_SIGNAL_SELECT_TWO = 8'h32;
    localparam logic [7:0] OFS_TEST_BUS_STATUS = 8'h35;

    // Reset values
    localparam logic [7:0] RST_RESERVED_TEST_SLOT = 8'h00;
    localparam logic [7:0] RST_TEST_SIGNAL_SELECT_ONE = 8'h00;
    localparam logic [7:0] RST_TEST_SIGNAL_SELECT_TWO = 8'h00;

    // Field positions in test_signal_select_two
    localparam int POS_TEST_BUS_REORDER = 7;
    localparam int POS_PRBS9_ENABLE = 6;
    localparam int POS_PRBS15_ENABLE = 5;

    // Analogue auxiliary select code that routes the test bit
    localparam logic [3:0] AUX_ROUTE_CODE = 4'hF;

    // Sequence seed after a start
    localparam logic [14:0] LFSR_SEED = 15'h7FFF;

    // Generator modes
    typedef enum logic [1:0] {
        TBSP_MODE_NORMAL,
        TBSP_MODE_PRBS9,
        TBSP_MODE_PRBS15
    } tbsp_mode_e;

endpackage

// ===== core/tbsp_top.sv
/*
 * Test-bus signal selection, parallel test port ordering and PRBS9/PRBS15
 * byte generation for the transmitter, with its register port.
 * Assumes test buses, transmit command and normal data come from logic on
 * CLOCK; pin-level tristating is done outside from the enables.
 */
// Behaviour
// R1: A three-bit select picks one line of the selected test bus for the multifunction output.
// R2: When the auxiliary_pin_two analogue select is all ones the selected line also drives one auxiliary pin.
// R3: With the reorder bit set the parallel port carries bits 4,3,2,6,5,0 instead of 5..0.
// R4: Bit 6 of select register two starts and enables PRBS9 generation.
// R5: Bit 5 of select register two starts and enables PRBS15 generation.
// R6: Software configures all transmit settings before enabling a sequence mode.
// R7: An enabled sequence is only sent after the Transmit command.
// R8: The low five bits of select register two choose the presented test bus.
// R9: Offset 30h is reserved, has no function and reads zero.
// R10: Select register one resets to zero and its upper five bits are reserved.
// R11: The status register reads the eight bits of the currently chosen test bus.
// R12: With no sequence enabled normal data is sent, and clearing an enable stops the sequence.
`timescale 1ns/10ps
`default_nettype none

module tbsp_top
    import tbsp_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    input wire logic [NUM_BUSES*8-1:0] TEST_BUSES,
    input wire logic [3:0] ANALOGUE_AUXILIARY_PIN_TWO_SELECT,
    input wire logic AUX_TARGET,
    output logic MULTIFUNCTION_OUTPUT_PIN,
    output logic AUXILIARY_PIN_ONE,
    output logic AUXILIARY_PIN_ONE_OE,
    output logic AUXILIARY_PIN_TWO,
    output logic AUXILIARY_PIN_TWO_OE,
    output logic [PAR_W-1:0] PARALLEL_TEST_PORT,
    input wire logic TRANSMIT_START,
    input wire logic [7:0] NORMAL_DATA,
    input wire logic NORMAL_VALID,
    output logic NORMAL_READY,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY
);

    typedef struct packed {
        logic [BIT_SEL_W-1:0] sel1;
        logic [7:0] sel2;
        logic [7:0] rdata;
        logic mf;
        logic auxiliary_pin_one;
        logic auxiliary_pin_one_oe;
        logic auxiliary_pin_two;
        logic auxiliary_pin_two_oe;
        logic [PAR_W-1:0] par;
        tbsp_mode_e mode;
        logic active;
        logic [LFSR_W-1:0] lfsr;
        logic out_v;
        logic [7:0] out_d;
        logic skid_v;
        logic [7:0] skid_d;
        logic src_rdy;
        logic norm_rdy;
    } tbsp_state_s;

    tbsp_state_s st_q;
    tbsp_state_s st_d;
    logic rst_meta_q;
    logic rst_n_q;
    logic chk_en_q;
    logic [7:0] cur_bus;
    logic cur_bit;
    logic [PAR_W-1:0] par_val;
    tbsp_mode_e mode_sel;
    logic in_v;
    logic [7:0] in_d;
    logic fire;
    logic take;
    logic [22:0] gen;

    // Eight sequence steps; returns {byte, next state}
    function automatic logic [22:0] prbs_byte(input logic [LFSR_W-1:0] s, input logic is9);
        logic [LFSR_W-1:0] r;
        logic [7:0] b;
        logic nb;
        r = s;
        b = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            nb = is9 ? (r[8] ^ r[4]) : (r[14] ^ r[13]);
            r = {r[LFSR_W-2:0], nb};
            b = {b[6:0], nb};
        end
        return {b, r};
    endfunction

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
            chk_en_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
            // Checks start once the state has left reset
            chk_en_q <= rst_n_q;
        end
    end

    always_comb
    begin
        cur_bus = TEST_BUSES[{st_q.sel2[BUS_SEL_W-1:0], 3'b000} +: 8]; // R8
        cur_bit = cur_bus[st_q.sel1]; // R1
        if (st_q.sel2[POS_TEST_BUS_REORDER])
        begin
            par_val = {cur_bus[4], cur_bus[3], cur_bus[2], cur_bus[6], cur_bus[5], cur_bus[0]}; // R3
        end
        else
        begin
            par_val = cur_bus[PAR_W-1:0];
        end
        if (st_q.sel2[POS_PRBS9_ENABLE])
        begin
            mode_sel = TBSP_MODE_PRBS9; // R4
        end
        else if (st_q.sel2[POS_PRBS15_ENABLE])
        begin
            mode_sel = TBSP_MODE_PRBS15; // R5
        end
        else
        begin
            mode_sel = TBSP_MODE_NORMAL;
        end
        gen = prbs_byte(st_q.lfsr, st_q.mode == TBSP_MODE_PRBS9);
        case (st_q.mode)
            TBSP_MODE_PRBS9, TBSP_MODE_PRBS15:
            begin
                in_v = st_q.active; // R7
                in_d = gen[22:15];
            end
            default:
            begin
                in_v = NORMAL_VALID; // R12
                in_d = NORMAL_DATA;
            end
        endcase
        fire = in_v && st_q.src_rdy;
        take = st_q.out_v && TX_READY;

        st_d = st_q;
        // Register port
        st_d.rdata = 8'h00;
        if (REG_WR)
        begin
            case (REG_ADDR)
                OFS_TEST_SIGNAL_SELECT_ONE: st_d.sel1 = REG_WDATA[BIT_SEL_W-1:0]; // R10
                OFS_TEST_SIGNAL_SELECT_TWO: st_d.sel2 = REG_WDATA;
                default: st_d.sel1 = st_q.sel1;
            endcase
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                OFS_RESERVED_TEST_SLOT: st_d.rdata = RST_RESERVED_TEST_SLOT; // R9
                OFS_TEST_SIGNAL_SELECT_ONE: st_d.rdata = {5'h00, st_q.sel1}; // R10
                OFS_TEST_SIGNAL_SELECT_TWO: st_d.rdata = st_q.sel2;
                OFS_TEST_BUS_STATUS: st_d.rdata = cur_bus; // R11
                default: st_d.rdata = 8'h00;
            endcase
        end

        // Test signal outputs
        st_d.mf = cur_bit; // R1
        st_d.auxiliary_pin_one = cur_bit;
        st_d.auxiliary_pin_two = cur_bit;
        st_d.auxiliary_pin_one_oe = (ANALOGUE_AUXILIARY_PIN_TWO_SELECT == AUX_ROUTE_CODE) && !AUX_TARGET; // R2
        st_d.auxiliary_pin_two_oe = (ANALOGUE_AUXILIARY_PIN_TWO_SELECT == AUX_ROUTE_CODE) && AUX_TARGET; // R2
        st_d.par = par_val; // R3

        // Sequence control; settings are taken as already prepared by software
        st_d.mode = mode_sel;
        if (mode_sel != st_q.mode)
        begin
            st_d.lfsr = LFSR_SEED; // R4 R5
            st_d.active = 1'b0; // R12
        end
        else if (mode_sel == TBSP_MODE_NORMAL)
        begin
            st_d.active = 1'b0; // R12
        end
        else
        begin
            if (TRANSMIT_START)
            begin
                st_d.active = 1'b1; // R6 R7
            end
            if (fire)
            begin
                st_d.lfsr = gen[LFSR_W-1:0];
            end
        end

        // Two-entry buffer toward the transmitter
        if (st_q.skid_v)
        begin
            if (take || !st_q.out_v)
            begin
                st_d.out_v = 1'b1;
                st_d.out_d = st_q.skid_d;
                st_d.skid_v = 1'b0;
            end
        end
        else if (fire)
        begin
            if (take || !st_q.out_v)
            begin
                st_d.out_v = 1'b1;
                st_d.out_d = in_d;
            end
            else
            begin
                st_d.skid_v = 1'b1;
                st_d.skid_d = in_d;
            end
        end
        else if (take)
        begin
            st_d.out_v = 1'b0;
        end
        st_d.src_rdy = !st_d.skid_v;
        st_d.norm_rdy = !st_d.skid_v && (mode_sel == TBSP_MODE_NORMAL); // R12
    end

    always_ff @(posedge CLOCK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q <= '0;
            st_q.sel1 <= RST_TEST_SIGNAL_SELECT_ONE[BIT_SEL_W-1:0]; // R10
            st_q.sel2 <= RST_TEST_SIGNAL_SELECT_TWO;
            st_q.mode <= TBSP_MODE_NORMAL;
            st_q.lfsr <= LFSR_SEED;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign REG_RDATA = st_q.rdata;
    assign MULTIFUNCTION_OUTPUT_PIN = st_q.mf;
    assign AUXILIARY_PIN_ONE = st_q.auxiliary_pin_one;
    assign AUXILIARY_PIN_ONE_OE = st_q.auxiliary_pin_one_oe;
    assign AUXILIARY_PIN_TWO = st_q.auxiliary_pin_two;
    assign AUXILIARY_PIN_TWO_OE = st_q.auxiliary_pin_two_oe;
    assign PARALLEL_TEST_PORT = st_q.par;
    assign TX_DATA = st_q.out_d;
    assign TX_VALID = st_q.out_v;
    assign NORMAL_READY = st_q.norm_rdy;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!chk_en_q);

    AST_MF_FOLLOWS_BIT: // R1
    assert property (1'b1 |=> MULTIFUNCTION_OUTPUT_PIN == $past(cur_bit))
        else $error("Multifunction output does not follow the selected line");
    AST_AUX_ROUTE: // R2
    assert property ((ANALOGUE_AUXILIARY_PIN_TWO_SELECT == AUX_ROUTE_CODE) && !AUX_TARGET
        |=> AUXILIARY_PIN_ONE_OE && AUXILIARY_PIN_ONE == $past(cur_bit) && !AUXILIARY_PIN_TWO_OE)
        else $error("Auxiliary pin one not driven with the test line");
    AST_AUX_QUIET: // R2
    assert property ((ANALOGUE_AUXILIARY_PIN_TWO_SELECT != AUX_ROUTE_CODE)
        |=> !AUXILIARY_PIN_ONE_OE && !AUXILIARY_PIN_TWO_OE)
        else $error("Auxiliary pin driven without the routing code");
    AST_REORDER: // R3
    assert property (st_q.sel2[POS_TEST_BUS_REORDER] |=> PARALLEL_TEST_PORT
        == {$past(cur_bus[4]), $past(cur_bus[3]), $past(cur_bus[2]),
            $past(cur_bus[6]), $past(cur_bus[5]), $past(cur_bus[0])})
        else $error("Parallel port order wrong under reorder");
    AST_PRBS9_START: // R4
    assert property ((st_q.mode == TBSP_MODE_NORMAL) && REG_WR
        && REG_ADDR == OFS_TEST_SIGNAL_SELECT_TWO && REG_WDATA[POS_PRBS9_ENABLE]
        |=> ##1 st_q.mode == TBSP_MODE_PRBS9 && st_q.lfsr == LFSR_SEED && !st_q.active)
        else $error("PRBS9 mode not started with a fresh seed");
    AST_PRBS15_START: // R5
    assert property ((st_q.mode == TBSP_MODE_NORMAL) && REG_WR
        && REG_ADDR == OFS_TEST_SIGNAL_SELECT_TWO
        && REG_WDATA[6:5] == 2'b01
        |=> ##1 st_q.mode == TBSP_MODE_PRBS15 && st_q.lfsr == LFSR_SEED)
        else $error("PRBS15 mode not started with a fresh seed");
    AST_WAIT_TRANSMIT: // R7
    assert property ($rose(st_q.active) |-> $past(TRANSMIT_START))
        else $error("Sequence started without the Transmit command");
    AST_NORMAL_PATH: // R8
    assert property (!st_q.sel2[POS_TEST_BUS_REORDER]
        |=> PARALLEL_TEST_PORT == $past(cur_bus[PAR_W-1:0]))
        else $error("Parallel port does not show the selected bus");
    AST_RESERVED_READ: // R9
    assert property (REG_RD && REG_ADDR == OFS_RESERVED_TEST_SLOT |=> REG_RDATA == 8'h00)
        else $error("Reserved slot reads non-zero");
    AST_SEL1_UPPER: // R10
    assert property (REG_RD && REG_ADDR == OFS_TEST_SIGNAL_SELECT_ONE |=> REG_RDATA[7:3] == 5'h00)
        else $error("Reserved bits of select register one read non-zero");
    AST_STATUS_READ: // R11
    assert property (REG_RD && REG_ADDR == OFS_TEST_BUS_STATUS |=> REG_RDATA == $past(cur_bus))
        else $error("Status read does not return the selected bus");
    AST_STOP_ON_CLEAR: // R12
    assert property (st_q.sel2[6:5] == 2'b00 |=> !st_q.active)
        else $error("Sequence still active with both enables clear");

endmodule

`default_nettype wire

// ===== testbench/tbsp_tx_sink.sv
/*
 * Transmitter model that takes the generated byte stream.
 * Assumes the block's CLOCK; stall holds ready low for back-pressure.
 */
`timescale 1ns/10ps
`default_nettype none

module tbsp_tx_sink
(
    input wire logic clock,
    input wire logic stall,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] got[$];

    initial tx_ready = 1'b0;
    // Takes a byte on a valid and ready edge; ready moves just after an edge
    always @(posedge clock)
    begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tx_ready <= !stall;
    end
endmodule

`default_nettype wire

// ===== testbench/test_test_bus_select_prbs.sv
/*
 * Self-checking bench: registers, test pins, normal stream and sequences.
 * Assumes tbsp_top and the transmitter model tbsp_tx_sink.
 */
`timescale 1ns/10ps
`default_nettype none

module test_test_bus_select_prbs;
    import tbsp_pkg::*;
    logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, n_data = 8'h00, tx_data;
    logic [255:0] test_buses;
    logic [3:0] aux_sel = 4'h0;
    logic aux_target = 1'b0, tx_start = 1'b0, n_valid = 1'b0, stall = 1'b0;
    logic mf, auxiliary_pin_one, auxiliary_pin_one_oe, auxiliary_pin_two, auxiliary_pin_two_oe, n_ready, tx_valid, tx_ready;
    logic [5:0] par;
    int n_fail = 0, checks = 0, cycles = 0;

    tbsp_top i_dut (.CLOCK(clock), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TEST_BUSES(test_buses),
        .ANALOGUE_AUXILIARY_PIN_TWO_SELECT(aux_sel), .AUX_TARGET(aux_target),
        .MULTIFUNCTION_OUTPUT_PIN(mf), .AUXILIARY_PIN_ONE(auxiliary_pin_one), .AUXILIARY_PIN_ONE_OE(auxiliary_pin_one_oe),
        .AUXILIARY_PIN_TWO(auxiliary_pin_two), .AUXILIARY_PIN_TWO_OE(auxiliary_pin_two_oe), .PARALLEL_TEST_PORT(par),
        .TRANSMIT_START(tx_start), .NORMAL_DATA(n_data), .NORMAL_VALID(n_valid),
        .NORMAL_READY(n_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready));
    tbsp_tx_sink i_sink (.clock(clock), .stall(stall), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));

    always #2 clock = ~clock;

    function automatic logic [7:0] busv(input int n);
        return 8'(n * 37 + 90);
    endfunction

    function automatic bit bt(input int i);
        return i_sink.got[i / 8][7 - i % 8];
    endfunction

    initial
        for (int n = 0; n < 32; n++)
            test_buses[8 * n +: 8] = busv(n);

    task automatic wrap_up();
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data stand one cycle, then return to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        @(posedge clock);
        #1;
        check(reg_rdata, 8'h00);
    endtask

    task automatic wait_got(input int n);
        for (int i = 0; i < 200 && i_sink.got.size() < n; i++)
            @(posedge clock);
        check(8'(i_sink.got.size() >= n), 8'h01);
    endtask

    // Bus status, line select, aux routing and parallel order for one bus
    task automatic t_lines(input logic [4:0] s, input logic f, input logic [3:0] code);
        logic [7:0] v;
        logic e1, e2;
        v = busv(s);
        wr(OFS_TEST_SIGNAL_SELECT_TWO, {f, 2'h0, s});
        aux_sel <= code;
        rd(OFS_TEST_SIGNAL_SELECT_TWO, {f, 2'h0, s});
        rd(OFS_TEST_BUS_STATUS, v);
        check({2'h0, par}, f ? {2'h0, v[4], v[3], v[2], v[6], v[5], v[0]} : {2'h0, v[5:0]});
        for (int b = 0; b < 8; b++)
        begin
            wr(OFS_TEST_SIGNAL_SELECT_ONE, 8'(b));
            aux_target <= b[1];
            repeat (3) @(posedge clock);
            #1;
            e1 = (code == 4'hF) && !b[1];
            e2 = (code == 4'hF) && b[1];
            check({7'h0, mf}, {7'h0, v[b]});
            check({4'h0, auxiliary_pin_one_oe, auxiliary_pin_two_oe, auxiliary_pin_one & auxiliary_pin_one_oe, auxiliary_pin_two & auxiliary_pin_two_oe},
                {4'h0, e1, e2, e1 & v[b], e2 & v[b]});
        end
    endtask

    // Normal words under a stalled receiver: fill until refused, then drain
    task automatic t_stream();
        logic [7:0] sent[$];
        bit ok;
        stall <= 1'b1;
        #1;
        i_sink.got.delete();
        ok = 1;
        while (ok && sent.size() < 8)
        begin
            @(posedge clock);
            n_valid <= 1'b1;
            n_data <= 8'hA0 + 8'(sent.size());
            ok = 0;
            for (int i = 0; i < 4 && !ok; i++)
            begin
                @(negedge clock);
                ok = (n_ready === 1'b1);
                @(posedge clock);
            end
            n_valid <= 1'b0;
            if (ok)
                sent.push_back(8'hA0 + 8'(sent.size()));
        end
        check(8'(sent.size() >= 2 && sent.size() < 8), 8'h01);
        stall <= 1'b0;
        wait_got(sent.size());
        for (int i = 0; i < sent.size(); i++)
            check(i_sink.got[i], sent[i]);
    endtask

    // Sequence waits for Transmit, obeys its recurrence, stops when cleared
    task automatic t_prbs(input logic [7:0] ctrl, input int k, input int n);
        bit ok, okr, nz;
        #1;
        i_sink.got.delete();
        wr(OFS_TEST_SIGNAL_SELECT_TWO, ctrl);
        repeat (10) @(posedge clock);
        #1;
        check({6'h0, tx_valid, n_ready}, 8'h00);
        @(posedge clock);
        tx_start <= 1'b1;
        @(posedge clock);
        tx_start <= 1'b0;
        wait_got(6);
        ok = 1;
        okr = 1;
        nz = 0;
        for (int i = n; i < 48; i++)
        begin
            ok &= bt(i) == (bt(i - n) ^ bt(i - k));
            okr &= bt(i) == (bt(i - n) ^ bt(i - (n - k)));
            nz |= bt(i);
        end
        check(8'((ok | okr) & nz), 8'h01);
        wr(OFS_TEST_SIGNAL_SELECT_TWO, 8'h00);
        repeat (10) @(posedge clock);
        #1;
        i_sink.got.delete();
        repeat (10) @(posedge clock);
        #1;
        check({6'h0, tx_valid, n_ready}, 8'h01);
        check(8'(i_sink.got.size()), 8'h00);
    endtask

    // Reset values, reserved slot and unmapped offsets
    task automatic t_regs();
        rd(OFS_RESERVED_TEST_SLOT, 8'h00);
        rd(OFS_TEST_SIGNAL_SELECT_ONE, 8'h00);
        rd(OFS_TEST_SIGNAL_SELECT_TWO, 8'h00);
        wr(OFS_RESERVED_TEST_SLOT, 8'hFF);
        rd(OFS_RESERVED_TEST_SLOT, 8'h00);
        wr(OFS_TEST_SIGNAL_SELECT_ONE, 8'hFF);
        rd(OFS_TEST_SIGNAL_SELECT_ONE, 8'h07);
        wr(8'h40, 8'h5A);
        rd(8'h40, 8'h00);
    endtask

    // Reset in mid-run with a sequence mode armed returns all to idle
    task automatic t_reset();
        wr(OFS_TEST_SIGNAL_SELECT_TWO, 8'hC3);
        wr(OFS_TEST_SIGNAL_SELECT_ONE, 8'h05);
        nrst <= 1'b0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check({6'h0, tx_valid, n_ready}, 8'h01);
        rd(OFS_TEST_SIGNAL_SELECT_ONE, 8'h00);
        rd(OFS_TEST_SIGNAL_SELECT_TWO, 8'h00);
    endtask

    initial
    begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_lines(5'h00, 1'b0, 4'hF);
        t_lines(5'h1F, 1'b1, 4'hF);
        t_lines(5'h0D, 1'b1, 4'hE);
        t_stream();
        // Nothing else here needs setting before a sequence mode
        t_prbs(8'h40, 5, 9);
        t_prbs(8'h20, 14, 15);
        t_prbs(8'h60, 5, 9);
        t_reset();
        wrap_up();
    end
endmodule

`default_nettype wire
